/* File: include/fds_pkg.sv */
package fds_pkg;
   // register byte addresses on the bus
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [14:0] CTRL_RESET = 15'h0000;
   // control word width
   localparam int CTRL_WIDTH = 15;
   // status word bit positions
   localparam int ST_FULL = 0;
   localparam int ST_NOT_EMPTY = 1;
   localparam int ST_TX_SERV = 2;
   localparam int ST_RX_SERV = 3;
   localparam int ST_DRQ = 4;
   localparam int ST_REFRESH = 5;
   localparam int ST_DONE = 6;
   localparam int ST_TX_START = 7;
   localparam int ST_FIFO_INT = 8;
   localparam int ST_COUNT_LSB = 16;
   // fifo geometry
   localparam logic [7:0] FIFO_DEPTH = 8'h80;
   // engine mode encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_TX = 2'h1;
   localparam logic [1:0] MODE_RX = 2'h2;
   // refresh limit base: 4 cycles shifted by the field
   localparam logic [5:0] REFRESH_BASE = 6'h04;
   // timing
   localparam int CLK_PERIOD_PS = 25000;
   localparam int REFRESH_GAP_PS = 350000;
   localparam int REFRESH_GAP_CYC = (REFRESH_GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam logic [4:0] REFRESH_GAP_LOAD = 5'(REFRESH_GAP_CYC - 1);

   typedef struct packed {
      logic [6:0] threshold;
      logic [1:0] engineMode;
      logic fifoIntEnable;
      logic stringMove;
      logic [1:0] refreshCount;
      logic burst;
      logic dmaEnable;
   } fds_ctrl_type;

   typedef enum logic [3:0] {
      DRQ_IDLE = 4'h1,
      DRQ_ACTIVE = 4'h2,
      DRQ_WAITACK = 4'h4,
      DRQ_GAP = 4'h8
   } fds_drq_state_type;
endpackage

/* File: design/fds_service.sv */
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - fifo interrupt = enable and any service request
// - control bit 0 enables dma
// - control bit 1 selects burst mode
// - drq only with transmit or receive enabled; code also raises it in mode 3 (as receive)
// - drq while room (tx) or data (rx)
// - single mode: one byte per drq
// - burst releases drq after 32 cycles max
// - refresh field limits to 4..32 cycles
// - counter preloads idle, decrements per cycle
// - zero count: drop drq, 350ns gap
// - single mode uses no refresh counter
// - threshold starts transmitter in tx mode, with or without dma
// - burst tx: full or refresh drops drq
// - burst rx: drq when data, drops otherwise
// - programmed i/o when dma disabled
// - string move paces accesses with iochrdy
// - tx request raised before transmitter active
// - rx request when count >= 128-threshold
// - tx request when count <= threshold
// - threshold ranges 0 through 127
module fds_service (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hsel,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [7:0] fifoCount,
   input wire logic dmaAckN,
   input wire logic terminalCount,
   input wire logic ioReadN,
   input wire logic ioWriteN,
   output logic dmaRequest,
   output logic fifoInterrupt,
   output logic ioChannelReady,
   output logic txStart
);
   logic rstSync1_reg;
   logic rstSync2_reg;
   logic rstN;
   fds_pkg::fds_ctrl_type ctrl_reg;
   logic wrPending_reg;
   logic [7:0] wrAddr_reg;
   logic [31:0] hrdata_reg;
   logic [1:0] ackSync_reg;
   logic [1:0] tcSync_reg;
   logic [1:0] rdSync_reg;
   logic [1:0] wrSync_reg;
   logic ackActive;
   logic ackPrev_reg;
   logic ioCyclePulse;
   fds_pkg::fds_drq_state_type state_reg;
   fds_pkg::fds_drq_state_type state_next;
   logic [5:0] refCnt_reg;
   logic [4:0] gapCnt_reg;
   logic blockDone_reg;
   logic drq_reg;
   logic fifoInt_reg;
   logic ioRdy_reg;
   logic txStart_reg;
   logic fifoFull;
   logic fifoNotEmpty;
   logic txServiceRequest;
   logic rxServiceRequest;
   logic transmitDir;
   logic dmaArmed;
   logic dataWanted;
   logic [31:0] statusWord;

   function automatic logic [5:0] refreshLimit(input logic [1:0] field);
      refreshLimit = fds_pkg::REFRESH_BASE << field;
   endfunction

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1_reg <= 1'b0;
         rstSync2_reg <= 1'b0;
      end else begin
         rstSync1_reg <= 1'b1;
         rstSync2_reg <= rstSync1_reg;
      end
   end
   assign rstN = rstSync2_reg;

   // pin synchronisers; stage 1 feeds stage 2 only
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ackSync_reg <= 2'h3;
         tcSync_reg <= 2'h0;
         rdSync_reg <= 2'h3;
         wrSync_reg <= 2'h3;
         ackPrev_reg <= 1'b0;
      end else begin
         ackSync_reg <= {ackSync_reg[0], dmaAckN};
         tcSync_reg <= {tcSync_reg[0], terminalCount};
         rdSync_reg <= {rdSync_reg[0], ioReadN};
         wrSync_reg <= {wrSync_reg[0], ioWriteN};
         ackPrev_reg <= ackActive;
      end
   end
   assign ackActive = !ackSync_reg[1];
   assign ioCyclePulse = ackActive && !ackPrev_reg;

   assign fifoFull = (fifoCount == fds_pkg::FIFO_DEPTH);
   assign fifoNotEmpty = (fifoCount != 8'h00);
   assign txServiceRequest = (fifoCount <= {1'b0, ctrl_reg.threshold});
   assign rxServiceRequest = (fifoCount >= (fds_pkg::FIFO_DEPTH - {1'b0, ctrl_reg.threshold}));
   assign transmitDir = !ctrl_reg.engineMode[1];
   assign dmaArmed = ctrl_reg.dmaEnable && (ctrl_reg.engineMode != fds_pkg::MODE_OFF) && !blockDone_reg;
   assign dataWanted = transmitDir ? !fifoFull : fifoNotEmpty;

   // bus slave: zero wait states, always OKAY
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         wrPending_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         wrPending_reg <= 1'b0;
         if (hsel && hready && htrans[1]) begin
            wrPending_reg <= hwrite;
            wrAddr_reg <= haddr[7:0];
            if (!hwrite && haddr[7:0] == fds_pkg::ADDR_CTRL) begin
               hrdata_reg <= {17'h00000, ctrl_reg};
            end else if (!hwrite && haddr[7:0] == fds_pkg::ADDR_STATUS) begin
               hrdata_reg <= statusWord;
            end else begin
               hrdata_reg <= 32'h0000_0000;
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ctrl_reg <= fds_pkg::fds_ctrl_type'(fds_pkg::CTRL_RESET);
      end else if (wrPending_reg && wrAddr_reg == fds_pkg::ADDR_CTRL) begin
         ctrl_reg <= fds_pkg::fds_ctrl_type'(hwdata[fds_pkg::CTRL_WIDTH-1:0]);
      end
   end

   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[fds_pkg::ST_FULL] = fifoFull;
      statusWord[fds_pkg::ST_NOT_EMPTY] = fifoNotEmpty;
      statusWord[fds_pkg::ST_TX_SERV] = txServiceRequest;
      statusWord[fds_pkg::ST_RX_SERV] = rxServiceRequest;
      statusWord[fds_pkg::ST_DRQ] = drq_reg;
      statusWord[fds_pkg::ST_REFRESH] = (state_reg == fds_pkg::DRQ_GAP);
      statusWord[fds_pkg::ST_DONE] = blockDone_reg;
      statusWord[fds_pkg::ST_TX_START] = txStart_reg;
      statusWord[fds_pkg::ST_FIFO_INT] = fifoInt_reg;
      statusWord[fds_pkg::ST_COUNT_LSB +: 8] = fifoCount;
   end

   // block ends at terminal count; set beats clear
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         blockDone_reg <= 1'b0;
      end else begin
         blockDone_reg <= (tcSync_reg[1] && ackActive)
            || (blockDone_reg && ctrl_reg.dmaEnable && ctrl_reg.engineMode != fds_pkg::MODE_OFF);
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         fds_pkg::DRQ_IDLE: begin
            if (dmaArmed && dataWanted) begin
               state_next = fds_pkg::DRQ_ACTIVE;
            end
         end
         fds_pkg::DRQ_ACTIVE: begin
            if (ioCyclePulse && !ctrl_reg.burst) begin
               state_next = fds_pkg::DRQ_WAITACK;
            end else if (ioCyclePulse && refCnt_reg == 6'h01) begin
               state_next = fds_pkg::DRQ_WAITACK;
            end else if (!(dmaArmed && dataWanted)) begin
               state_next = fds_pkg::DRQ_IDLE;
            end
         end
         fds_pkg::DRQ_WAITACK: begin
            if (!ackActive) begin
               state_next = ctrl_reg.burst ? fds_pkg::DRQ_GAP : fds_pkg::DRQ_IDLE;
            end
         end
         fds_pkg::DRQ_GAP: begin
            if (gapCnt_reg == 5'h00) begin
               state_next = fds_pkg::DRQ_IDLE;
            end
         end
         default: state_next = fds_pkg::DRQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_reg <= fds_pkg::DRQ_IDLE;
         drq_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         drq_reg <= (state_next == fds_pkg::DRQ_ACTIVE);
      end
   end

   // refresh counter: preload outside active, count i/o cycles
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         refCnt_reg <= fds_pkg::REFRESH_BASE;
      end else if (state_reg != fds_pkg::DRQ_ACTIVE) begin
         refCnt_reg <= refreshLimit(ctrl_reg.refreshCount);
      end else if (ioCyclePulse && ctrl_reg.burst && refCnt_reg != 6'h00) begin
         refCnt_reg <= refCnt_reg - 6'h01;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         gapCnt_reg <= fds_pkg::REFRESH_GAP_LOAD;
      end else if (state_reg != fds_pkg::DRQ_GAP) begin
         gapCnt_reg <= fds_pkg::REFRESH_GAP_LOAD;
      end else if (gapCnt_reg != 5'h00) begin
         gapCnt_reg <= gapCnt_reg - 5'h01;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         fifoInt_reg <= 1'b0;
      end else begin
         fifoInt_reg <= ctrl_reg.fifoIntEnable && (txServiceRequest || rxServiceRequest);
      end
   end

   // transmitter trigger once fifo filled past threshold
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         txStart_reg <= 1'b0;
      end else if (ctrl_reg.engineMode != fds_pkg::MODE_TX) begin
         txStart_reg <= 1'b0;
      end else if (!txServiceRequest) begin
         txStart_reg <= 1'b1;
      end
   end

   // string move: stretch access while fifo cannot serve
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         ioRdy_reg <= 1'b1;
      end else begin
         ioRdy_reg <= !(ctrl_reg.stringMove && !ctrl_reg.dmaEnable
            && ((!rdSync_reg[1] && !fifoNotEmpty) || (!wrSync_reg[1] && fifoFull)));
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = rstSync2_reg;
   assign hresp = 1'b0;
   assign dmaRequest = drq_reg;
   assign fifoInterrupt = fifoInt_reg;
   assign ioChannelReady = ioRdy_reg;
   assign txStart = txStart_reg;

   AST_INT_DROPS: assert property (@(posedge clk) disable iff (!rstN)
      !ctrl_reg.fifoIntEnable |=> !fifoInterrupt) else $error("fifo interrupt stayed with enable low");
   AST_NO_DMA: assert property (@(posedge clk) disable iff (!rstN)
      !ctrl_reg.dmaEnable |=> !dmaRequest) else $error("drq with dma disabled");
   AST_MODE_GATE: assert property (@(posedge clk) disable iff (!rstN)
      ctrl_reg.engineMode == fds_pkg::MODE_OFF |=> !dmaRequest) else $error("drq with engine off");
   AST_TX_FULL: assert property (@(posedge clk) disable iff (!rstN)
      transmitDir && fifoFull && !ioCyclePulse |=> !dmaRequest) else $error("drq with fifo full");
   AST_RX_EMPTY: assert property (@(posedge clk) disable iff (!rstN)
      !transmitDir && !fifoNotEmpty && !ioCyclePulse |=> !dmaRequest) else $error("drq with fifo empty");
   AST_SINGLE_ONE: assert property (@(posedge clk) disable iff (!rstN)
      dmaRequest && !ctrl_reg.burst && ioCyclePulse |=> !dmaRequest) else $error("single mode drq held");
   AST_BURST_LIMIT: assert property (@(posedge clk) disable iff (!rstN)
      dmaRequest && ctrl_reg.burst && ioCyclePulse && refCnt_reg == 6'h01 |=> !dmaRequest ##1 !dmaRequest)
      else $error("burst drq beyond limit");
   AST_PRELOAD: assert property (@(posedge clk) disable iff (!rstN)
      state_reg == fds_pkg::DRQ_IDLE |=> refCnt_reg == refreshLimit($past(ctrl_reg.refreshCount)))
      else $error("refresh preset not loaded");
   AST_GAP_LEN: assert property (@(posedge clk) disable iff (!rstN)
      $rose(state_reg == fds_pkg::DRQ_GAP) |-> (state_reg == fds_pkg::DRQ_GAP)[*8] ##6 (state_reg == fds_pkg::DRQ_GAP)
      ##1 (state_reg != fds_pkg::DRQ_GAP)) else $error("refresh gap wrong length");
   AST_SINGLE_NOGAP: assert property (@(posedge clk) disable iff (!rstN)
      !ctrl_reg.burst && state_reg == fds_pkg::DRQ_WAITACK && !ackActive |=> state_reg == fds_pkg::DRQ_IDLE)
      else $error("refresh gap in single mode");
   AST_IORDY: assert property (@(posedge clk) disable iff (!rstN)
      ctrl_reg.stringMove && !ctrl_reg.dmaEnable && !rdSync_reg[1] && !fifoNotEmpty |=> !ioChannelReady)
      else $error("iochrdy not stretched");
   COV_GAP: cover property (@(posedge clk) disable iff (!rstN) state_reg == fds_pkg::DRQ_GAP);
   COV_SINGLE: cover property (@(posedge clk) disable iff (!rstN) dmaRequest && !ctrl_reg.burst && ioCyclePulse);
   COV_INT: cover property (@(posedge clk) disable iff (!rstN) $rose(fifoInterrupt));
endmodule // fds_service

/* File: verification/fds_dma_host.sv */
`timescale 1ns/1ps
module fds_dma_host (
   input wire logic clk,
   input wire logic resetn,
   input wire logic restart,
   input wire logic [7:0] blockLen,
   input wire logic dmaRequest,
   output logic dmaAckN,
   output logic terminalCount,
   output logic [7:0] byteCount,
   output logic [7:0] maxRun,
   output logic [7:0] minGap,
   output logic aen
);
   logic [7:0] run;
   logic [7:0] gap;
   logic ackStart = 1'b0;
   // one acknowledge cycle per byte, tc only on the last byte of the block
   initial begin
      dmaAckN = 1'b1;
      terminalCount = 1'b0;
      aen = 1'b0;
      forever begin
         @(posedge clk);
         if (resetn && dmaRequest && !restart) begin
            terminalCount <= (byteCount == blockLen - 8'h01);
            aen <= 1'b1;
            dmaAckN <= 1'b0;
            ackStart <= 1'b1;
            @(posedge clk);
            ackStart <= 1'b0;
            repeat (3) @(posedge clk);
            dmaAckN <= 1'b1;
            aen <= 1'b0;
            terminalCount <= 1'b0;
            repeat (3) @(posedge clk);
         end
      end
   end
   // bytes per request and idle gaps between requests
   always @(posedge clk) begin
      if (restart) begin
         byteCount <= 8'h00;
         maxRun <= 8'h00;
         minGap <= 8'hFF;
         run <= 8'h00;
         gap <= 8'h00;
      end else begin
         byteCount <= byteCount + {7'h00, ackStart};
         if (run > maxRun) begin
            maxRun <= run;
         end
         if (!dmaRequest) begin
            run <= 8'h00;
            gap <= gap + 8'h01;
         end else begin
            run <= run + {7'h00, ackStart};
            gap <= 8'h00;
            if (gap != 8'h00 && byteCount != 8'h00 && gap < minGap) begin
               minGap <= gap;
            end
         end
      end
   end
endmodule // fds_dma_host

/* File: verification/tb.sv */
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hsel = 1'b0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [7:0] fifoCount = 8'h00;
   logic ioReadN = 1'b1;
   logic ioWriteN = 1'b1;
   logic restart = 1'b0;
   logic [7:0] blockLen = 8'hFF;
   logic dmaAckN;
   logic terminalCount;
   logic dmaRequest;
   logic fifoInterrupt;
   logic ioChannelReady;
   logic txStart;
   logic [7:0] byteCount;
   logic [7:0] maxRun;
   logic [7:0] minGap;
   logic aen;
   logic [31:0] rd;
   int errors = 0;
   int n_tests = 0;
   always #12.5 clk = ~clk;
   fds_service dut (.clk(clk), .resetn(resetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hsel(hsel), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .fifoCount(fifoCount), .dmaAckN(dmaAckN),
      .terminalCount(terminalCount), .ioReadN(ioReadN), .ioWriteN(ioWriteN),
      .dmaRequest(dmaRequest), .fifoInterrupt(fifoInterrupt), .ioChannelReady(ioChannelReady),
      .txStart(txStart));
   fds_dma_host host (.clk(clk), .resetn(resetn), .restart(restart), .blockLen(blockLen),
      .dmaRequest(dmaRequest), .dmaAckN(dmaAckN), .terminalCount(terminalCount),
      .byteCount(byteCount), .maxRun(maxRun), .minGap(minGap), .aen(aen));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsel <= 1'b1;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   function automatic logic [31:0] ctl(input logic dma, input logic bst, input logic [1:0] rc,
         input logic sm, input logic ie, input logic [1:0] md, input logic [6:0] th);
      fds_pkg::fds_ctrl_type c;
      c = '{th, md, ie, sm, rc, bst, dma};
      return {17'h0, c};
   endfunction
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   // quiet the channel, clear the far side, then start a new setup
   task automatic fresh(input logic [31:0] c, input logic [7:0] cnt, input logic [7:0] len);
      ahb(1'b1, fds_pkg::ADDR_CTRL, 32'h0);
      repeat (20) @(posedge clk);
      restart <= 1'b1;
      fifoCount <= cnt;
      blockLen <= len;
      @(posedge clk);
      restart <= 1'b0;
      ahb(1'b1, fds_pkg::ADDR_CTRL, c);
   endtask
   task automatic wait_bytes(input int n);
      for (int i = 0; i < 4000 && int'(byteCount) < n; i++) @(posedge clk);
   endtask
   initial begin
      #1500000;
      errors++;
      wrap_up();
   end
   initial begin
      int ths[3];
      int cs[6];
      logic [1:0] md[4];
      int mc[4];
      logic seen;
      ths = '{0, 50, 127};
      md = '{fds_pkg::MODE_TX, fds_pkg::MODE_TX, fds_pkg::MODE_RX, 2'h3};
      mc = '{128, 127, 0, 1};
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      restart <= 1'b1;
      repeat (3) @(posedge clk);
      restart <= 1'b0;
      ahb(1'b0, fds_pkg::ADDR_CTRL, 32'h0);
      check(rd, {17'h0, fds_pkg::CTRL_RESET});
      ahb(1'b0, 8'h08, 32'h0);
      check(rd, 32'h0);
      foreach (ths[t]) begin
         cs = '{0, ths[t], ths[t] + 1, 127 - ths[t], 128 - ths[t], 128};
         ahb(1'b1, fds_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 1, fds_pkg::MODE_OFF, 7'(ths[t])));
         foreach (cs[k]) begin
            fifoCount <= 8'(cs[k]);
            settle(3);
            check(fifoInterrupt, cs[k] <= ths[t] || cs[k] >= 128 - ths[t]);
            ahb(1'b0, fds_pkg::ADDR_STATUS, 32'h0);
            check(rd[fds_pkg::ST_TX_SERV], cs[k] <= ths[t]);
            check(rd[fds_pkg::ST_RX_SERV], cs[k] >= 128 - ths[t]);
         end
      end
      ahb(1'b1, fds_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 0, fds_pkg::MODE_OFF, 7'd50));
      settle(2);
      check(fifoInterrupt, 1'b0);
      // interrupt driven host: five bytes per interrupt until it drops
      for (int d = 0; d < 2; d++) begin
         ahb(1'b1, fds_pkg::ADDR_CTRL, ctl(0, 0, 0, 0, 1, d ? fds_pkg::MODE_RX : fds_pkg::MODE_TX, 7'h32));
         fifoCount <= d ? 8'h64 : 8'h28;
         for (int b = 0; b < 8; b++) begin
            settle(3);
            if (fifoInterrupt === 1'b1) begin
               fifoCount <= d ? fifoCount - 8'h05 : fifoCount + 8'h05;
            end
         end
         check(fifoCount, d ? 8'h4B : 8'h37);
         check(fifoInterrupt, 1'b0);
      end
      for (int i = 0; i < 2; i++) begin
         fresh(i ? ctl(0, 1, 0, 0, 0, fds_pkg::MODE_TX, 0) : ctl(1, 1, 0, 0, 0, fds_pkg::MODE_OFF, 0), 10, 255);
         settle(40);
         check(byteCount, 0);
      end
      fresh(ctl(1, 1, 0, 0, 0, fds_pkg::MODE_TX, 7'd10), 5, 255);
      settle(10);
      check(txStart, 1'b0);
      fifoCount <= 8'd11;
      settle(4);
      check(txStart, 1'b1);
      wait_bytes(int'(byteCount) + 2);
      check(byteCount > 8'd1, 1'b1);
      foreach (md[k]) begin
         fresh(ctl(1, 1, 3, 0, 0, md[k], 0), 8'(mc[k]), 255);
         settle(60);
         check(byteCount != 8'h00, k % 2);
      end
      fresh(ctl(1, 0, 0, 0, 0, fds_pkg::MODE_TX, 0), 10, 3);
      wait_bytes(3);
      settle(60);
      check(byteCount, 3);
      check(maxRun, 1);
      check(minGap < 8'(fds_pkg::REFRESH_GAP_CYC), 1'b1);
      check(dmaRequest, 1'b0);
      check(aen, 1'b0);
      for (int rc = 0; rc < 4; rc++) begin
         fresh(ctl(1, 1, 2'(rc), 0, 0, fds_pkg::MODE_TX, 0), 10, 255);
         wait_bytes((4 << rc) + 2);
         check(maxRun, 4 << rc);
         check(minGap >= 8'(fds_pkg::REFRESH_GAP_CYC), 1'b1);
      end
      mc = '{5, 0, 128, 0};
      for (int i = 0; i < 3; i++) begin
         fresh(ctl(0, 0, 0, 1, 0, i == 2 ? fds_pkg::MODE_TX : fds_pkg::MODE_RX, 0), 8'(mc[i]), 255);
         ahb(1'b0, fds_pkg::ADDR_STATUS, 32'h0);
         check(rd[fds_pkg::ST_NOT_EMPTY], i != 1);
         check(rd[fds_pkg::ST_FULL], i == 2);
         seen = 1'b0;
         ioReadN <= (i == 2);
         ioWriteN <= (i != 2);
         for (int j = 0; j < 8; j++) begin
            settle(1);
            seen = seen | (ioChannelReady === 1'b0);
         end
         ioReadN <= 1'b1;
         ioWriteN <= 1'b1;
         check(seen, i != 0);
         settle(10);
      end
      wrap_up();
   end
endmodule // tb
